// ---- common/rpdl_pkg.sv ----
/*
  Constants for the reset-pulse and decade-latch host controller.
  Assumes a 40 MHz system clock; times are in nanoseconds.
*/
package rpdl_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // Settle time before transfer: 12 us plus 7 us per extra decade
  localparam int SETTLE_BASE_NS = 12000;
  localparam int SETTLE_PER_DECADE_NS = 7000;
  localparam int T2_MIN_NS = 8000;
  localparam int T3_MIN_NS = 15000;
  localparam int STAGGER_NS = 25000;
  // Width of each reset pulse the host drives on the trigger line
  localparam int TRIG_PULSE_NS = 15000;
  // Least times round up to whole cycles
  localparam int T2_CYC = (T2_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T3_CYC = (T3_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGGER_CYC = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int DIGITS = 10;
  localparam logic [9:0] DIGIT_IDLE = 10'h3FF;
  localparam int HOUR_TERMINAL = 23;
  localparam int MINUTE_TERMINAL = 59;
  // Power-up memory-reset hold before counter trigger edge
  localparam int PWRUP_NS = 50000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic int settleCycles(input int decades);
    settleCycles = (SETTLE_BASE_NS + SETTLE_PER_DECADE_NS * (decades - 1)
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
endpackage

// ---- core/rpdl_decode.sv ----
/*
  Combinational BCD 1248 to active-low one-of-ten decoder.
  Assumes the BCD value is already in the sys_clk domain.
*/
`timescale 1ns/1ps
module rpdl_decode (
  // Binary digit
  input wire logic [3:0] bcdIn,
  // Active-low one-hot digit
  output logic [9:0] digitN
);
  always_comb begin
    digitN = rpdl_pkg::DIGIT_IDLE;
    // Codes above nine give no low line
    if (bcdIn < 4'(rpdl_pkg::DIGITS)) begin
      digitN[bcdIn] = 1'b0;
    end
  end
endmodule // rpdl_decode

// ---- core/rpdl_host.sv ----
/*
  Host controller that drives a reset-pulse generator and a chain of
  decade buffer latches through their pins.
  Assumes the generator and latches are external; their feedback pins
  arrive asynchronously and are synchronised here.
  Transfer strobes rest high: a latch wipes its digit while its strobe is low.
*/
// How it works
// - Host lowers gate only while trigger is low.
// - Memory reset feeds back to hold trigger high during preset reset.
// - Host resets counters and memories at power-up.
// - Memories reset first, then trigger edge resets counters.
// - Each stage resets at its own terminal count, else inhibited.
// - Exactly one digit input low at capture edge; a BCD code above nine leaves all ten lines high.
// - Transfer pulse comes from a capture request, or is held low during the power-up memory clear.
// - Transfer timing keeps settle, 8 us and 15 us limits.
// - Binary counters pass a BCD to one-of-ten decoder first.
// - Chain transfers issue in order, 25 us apart.
// - Counter outputs are active-low one-hot.
`timescale 1ns/1ps
module rpdl_host #(
  parameter int DECADES = 1,
  parameter int STAGES = 2,
  parameter int PWRUP_CYCLES = rpdl_pkg::PWRUP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // User requests
  input wire logic resetReq,
  input wire logic captureReq,
  input wire logic [3:0] countBcd,
  input wire logic [6:0] stageCount,
  input wire logic stageIsHours,
  // Generator pins
  output logic trigOut,
  output logic gateOut,
  input wire logic memResetIn,
  // Counter digit out to first latch
  output logic [9:0] digitOut,
  // Latch transfer strobes, far stage (STAGES-1) first
  output logic [STAGES-1:0] xferOut,
  // Status
  output logic busy,
  output logic pwrupDone
);
  typedef enum {ST_PWR_MEM, ST_PWR_TRIG, ST_IDLE, ST_TRIG, ST_TRIG_LOW,
    ST_SETTLE, ST_XFER, ST_GAP} rpdl_state_t;

  localparam logic [rpdl_pkg::CNT_W-1:0] SETTLE_CYC =
    rpdl_pkg::CNT_W'(rpdl_pkg::settleCycles(DECADES));
  localparam logic [rpdl_pkg::CNT_W-1:0] TRIG_CYC = rpdl_pkg::CNT_W'(rpdl_pkg::TRIG_CYC);
  localparam logic [rpdl_pkg::CNT_W-1:0] T2_CYC = rpdl_pkg::CNT_W'(rpdl_pkg::T2_CYC);
  localparam logic [rpdl_pkg::CNT_W-1:0] STAG_CYC =
    rpdl_pkg::CNT_W'(rpdl_pkg::STAGGER_CYC);
  localparam logic [rpdl_pkg::CNT_W-1:0] T3_CYC = rpdl_pkg::CNT_W'(rpdl_pkg::T3_CYC);
  localparam logic [rpdl_pkg::CNT_W-1:0] PWR_CYC = rpdl_pkg::CNT_W'(PWRUP_CYCLES);

  rpdl_state_t state_reg;
  logic [rpdl_pkg::CNT_W-1:0] timer_reg;
  logic [$clog2(STAGES+1)-1:0] stage_reg;
  logic memSync1_reg, memSync2_reg;
  logic [9:0] decoded;
  logic terminal;
  logic [STAGES-1:0] stageFire;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Phase timer has run its full count
  function automatic logic reached(input logic [rpdl_pkg::CNT_W-1:0] count,
      input logic [rpdl_pkg::CNT_W-1:0] limit);
    reached = (count >= limit);
  endfunction

  // Strobe select for the stage being served; the far end of the chain goes first
  function automatic logic [STAGES-1:0] stageSelect(
      input logic [$clog2(STAGES+1)-1:0] idx);
    stageSelect = '0;
    for (int i = 0; i < STAGES; i++) begin
      stageSelect[i] = (int'(idx) == STAGES - 1 - i);
    end
  endfunction

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      memSync1_reg <= 1'b0;
      memSync2_reg <= 1'b0;
    end else begin
      memSync1_reg <= memResetIn;
      memSync2_reg <= memSync1_reg;
    end
  end

  rpdl_decode uDecode (
    .bcdIn(countBcd),
    .digitN(decoded)
  );

  // Stage reset allowed only at its own terminal count
  assign terminal = stageIsHours ? (stageCount == 7'(rpdl_pkg::HOUR_TERMINAL))
                                 : (stageCount == 7'(rpdl_pkg::MINUTE_TERMINAL));

  // ----------------------------------------
  // Transfer strobe select
  // ----------------------------------------
  // Only one stage is served at a time, so outside power-up at most one strobe is low
  assign stageFire = (state_reg == ST_XFER) ? stageSelect(stage_reg) : '0;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_PWR_MEM;
      timer_reg <= '0;
      stage_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 1'b1;
      unique case (state_reg)
        ST_PWR_MEM: begin
          // Memories clear first; counters wait for the power-up hold time
          if (reached(timer_reg, PWR_CYC)) begin
            state_reg <= ST_PWR_TRIG;
            timer_reg <= '0;
          end
        end
        ST_PWR_TRIG, ST_TRIG: begin
          // Hold trigger while the memory-reset echo stands
          if (reached(timer_reg, TRIG_CYC) && !memSync2_reg) begin
            state_reg <= ST_TRIG_LOW;
            timer_reg <= '0;
          end
        end
        ST_TRIG_LOW: begin
          // Trigger rests low before any new request may start
          if (reached(timer_reg, T3_CYC)) begin
            state_reg <= ST_IDLE;
            timer_reg <= '0;
          end
        end
        ST_IDLE: begin
          // Requests are looked at only here, one at a time; a reset at terminal count wins
          timer_reg <= '0;
          stage_reg <= '0;
          if (resetReq && terminal) begin
            state_reg <= ST_TRIG;
          end else if (captureReq) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // Counter outputs settle before the first transfer edge
          if (reached(timer_reg, SETTLE_CYC)) begin
            state_reg <= ST_XFER;
            timer_reg <= '0;
          end
        end
        ST_XFER: begin
          // Strobe low time meets the 8 us minimum
          if (reached(timer_reg, T2_CYC)) begin
            state_reg <= ST_GAP;
            timer_reg <= '0;
          end
        end
        ST_GAP: begin
          // Last stage first, so each digit moves one place on
          if (reached(timer_reg, STAG_CYC)) begin
            timer_reg <= '0;
            if (stage_reg == ($clog2(STAGES+1))'(STAGES - 1)) begin
              state_reg <= ST_IDLE;
            end else begin
              stage_reg <= stage_reg + 1'b1;
              state_reg <= ST_XFER;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigOut <= 1'b0;
      gateOut <= 1'b1;
      digitOut <= rpdl_pkg::DIGIT_IDLE;
      xferOut <= '0;
    end else begin
      trigOut <= (state_reg == ST_PWR_TRIG) || (state_reg == ST_TRIG);
      // Gate only moves while trigger is low, so no stray pulse
      if (!trigOut) begin
        gateOut <= (state_reg == ST_PWR_MEM) || (state_reg == ST_SETTLE)
          || (state_reg == ST_XFER) || (state_reg == ST_GAP);
      end
      digitOut <= decoded;
      // Strobes rest high so every latch keeps its digit; a low level wipes it
      if (state_reg == ST_PWR_MEM) begin
        // Held low while the memories clear, so no stale digit survives
        xferOut <= '0;
      end else begin
        // Low for the transfer time; the latch takes its input on the way back up
        xferOut <= ~stageFire;
      end
    end
  end

  assign busy = (state_reg != ST_IDLE);
  assign pwrupDone = (state_reg != ST_PWR_MEM) && (state_reg != ST_PWR_TRIG);
endmodule // rpdl_host

// ---- sim/rpdl_gen_model.sv ----
/* Behavioural reset generator and buffer latch facing the host.
   Assumes trigger, gate and strobes come from host registers on sys_clk. */
`timescale 1ns/1ps
module rpdl_gen_model #(
  parameter int W = 40
) (
  // Host pins
  input wire logic clk,
  input wire logic trig,
  input wire logic gate,
  // Reset outputs and pulse tally
  output logic memReset,
  output logic ctrReset,
  output int pulses
);
  // ---------------
  // Edge detection
  // ---------------
  logic trigQ = 1'b0;
  logic gateQ = 1'b1;
  int left = 0;
  int count = 0;
  // No retrigger while a pulse runs: the host holds trigger through it
  always @(posedge clk) begin
    if (left == 0 && trig && ((!trigQ && !gate) || (gateQ && !gate))) begin
      left <= W;
      count <= count + 1;
    end else if (left > 0) begin
      left <= left - 1;
    end
    trigQ <= trig;
    gateQ <= gate;
  end
  assign memReset = left > 0;
  assign ctrReset = left > 0;
  assign pulses = count;
endmodule // rpdl_gen_model

// ---------------
// Buffer latch
// ---------------
module rpdl_latch_model (
  // Transfer strobe and active-low digit in
  input wire logic xfer,
  input wire logic [9:0] digitIn,
  // Stored digit, active low
  output logic [9:0] digitQ
);
  // No clock: a low strobe wipes the digit, the rising edge takes the input
  always @(xfer) begin
    if (xfer === 1'b1) begin
      digitQ <= digitIn;
    end else begin
      digitQ <= rpdl_pkg::DIGIT_IDLE;
    end
  end
endmodule // rpdl_latch_model

// ---- sim/rpdl_host_asserts.sv ----
/* Port checker for the reset and latch host.
   Assumes one clock domain; bound below. */
`timescale 1ns/1ps
module rpdl_host_asserts #(
  parameter int STAGES = 2,
  parameter int PWRUP_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] countBcd,
  input wire logic trigOut,
  input wire logic gateOut,
  input wire logic [9:0] digitOut,
  input wire logic [STAGES-1:0] xferOut,
  input wire logic busy,
  input wire logic pwrupDone
);
  // ---------------
  // Cycle counters
  // ---------------
  localparam int STAG_MIN = rpdl_pkg::STAGGER_CYC;
  localparam int STAG_MAX = 1400;
  int tCnt;
  int xCnt;
  int rCnt;
  int sCnt;
  logic farQ;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tCnt <= 0;
      xCnt <= 0;
      rCnt <= 0;
      sCnt <= 0;
      farQ <= 1'b0;
    end else begin
      tCnt <= trigOut ? tCnt + 1 : 0;
      // Strobes rest high; this counts the low transfer time
      xCnt <= (&xferOut) ? 0 : xCnt + 1;
      if (rCnt < 100000) rCnt <= rCnt + 1;
      // Cycles since the far stage took its digit; saturates so it never wraps
      farQ <= xferOut[STAGES-1];
      if (xferOut[STAGES-1] && !farQ) begin
        sCnt <= 1;
      end else if (sCnt < 100000) begin
        sCnt <= sCnt + 1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_gate_fall_safe: assert property ($fell(gateOut) |-> !$past(trigOut))
    else $error("gate lowered while trigger high");
  a_trig_hold_time: assert property ($fell(trigOut) |-> tCnt >= 600)
    else $error("trigger pulse too short");
  a_pwrup_order: assert property ($rose(trigOut) && !pwrupDone |-> rCnt >= PWRUP_CYCLES - 1)
    else $error("power-up trigger too early");
  a_xfer_width: assert property ($rose(&xferOut) && pwrupDone |-> xCnt == 321)
    else $error("transfer width wrong");
  a_xfer_one_stage: assert property (pwrupDone |-> $onehot0(~xferOut))
    else $error("two transfers at once");
  a_xfer_stagger: assert property (
    $rose(xferOut[0]) && pwrupDone |-> sCnt >= STAG_MIN && sCnt <= STAG_MAX)
    else $error("chain transfers out of order");
  a_capture_digit: assert property (
    $rose(xferOut[0]) && pwrupDone |-> digitOut == ~(10'h001 << countBcd))
    else $error("digit not one-hot at capture");
  a_digit_form: assert property ($onehot0(~digitOut))
    else $error("digit not active-low one-hot");
  a_idle_quiet: assert property (!busy |-> !trigOut && (&xferOut))
    else $error("activity while idle");
  c_capture: cover property ($rose(xferOut[0]) && pwrupDone);
  c_trigger: cover property ($rose(trigOut) && pwrupDone);
  c_pwrup: cover property ($rose(pwrupDone));
endmodule // rpdl_host_asserts
bind rpdl_host rpdl_host_asserts #(.STAGES(STAGES), .PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .countBcd(countBcd), .trigOut(trigOut),
  .gateOut(gateOut), .digitOut(digitOut), .xferOut(xferOut), .busy(busy),
  .pwrupDone(pwrupDone));

// ---- sim/rpdl_host_bench.sv ----
/* Self-checking bench for the reset and latch host.
   Assumes the generator model and the bound checker. */
`timescale 1ns/1ps
module rpdl_host_bench;
  logic sys_clk = 0, reset_n = 0, resetReq = 0, captureReq = 0, stageIsHours = 0;
  logic [3:0] countBcd = 4'h7;
  logic [6:0] stageCount = 7'h00;
  logic trigOut, gateOut, memResetIn, busy, pwrupDone;
  logic [9:0] digitOut;
  logic [1:0] xferOut;
  logic [9:0] nearQ, farQ, nearExp, farExp;
  int failures = 0, n_compared = 0, pulses, p0;
  always #12.5 sys_clk = ~sys_clk;
  rpdl_host #(.PWRUP_CYCLES(20)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .resetReq(resetReq), .captureReq(captureReq), .countBcd(countBcd),
    .stageCount(stageCount), .stageIsHours(stageIsHours), .trigOut(trigOut),
    .gateOut(gateOut), .memResetIn(memResetIn), .digitOut(digitOut), .xferOut(xferOut),
    .busy(busy), .pwrupDone(pwrupDone));
  rpdl_gen_model gen (.clk(sys_clk), .trig(trigOut), .gate(gateOut),
    .memReset(memResetIn), .ctrReset(), .pulses(pulses));
  rpdl_latch_model lat0 (.xfer(xferOut[0]), .digitIn(digitOut), .digitQ(nearQ));
  rpdl_latch_model lat1 (.xfer(xferOut[1]), .digitIn(nearQ), .digitQ(farQ));
  // ---------------
  // Shared tasks
  // ---------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task automatic stop_test;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge sys_clk);
    if (busy !== 1'b0) begin
      failures++;
      stop_test;
    end
  endtask
  task automatic request(input logic rr, input logic cr);
    @(negedge sys_clk);
    {resetReq, captureReq} = {rr, cr};
    @(negedge sys_clk);
    {resetReq, captureReq} = 2'b00;
    repeat (2) @(negedge sys_clk);
    wait_idle;
  endtask
  // ---------------
  // Scenarios
  // ---------------
  task automatic t_powerup;
    repeat (5) @(negedge sys_clk);
    check({trigOut, gateOut, xferOut}, 10'h004, "reset levels");
    reset_n = 1;
    wait_idle;
    check(10'(pwrupDone), 10'h001, "power-up not done");
    check(10'(pulses), 10'h001, "power-up pulse count");
    nearExp = ~(10'h001 << countBcd);
    check(nearQ, nearExp, "near stage after power-up");
    check(farQ, 10'h3FF, "far stage after power-up");
  endtask
  task automatic t_capture(input logic [3:0] d);
    countBcd = d;
    p0 = pulses;
    farExp = nearExp;
    nearExp = ~(10'h001 << d);
    @(negedge sys_clk);
    captureReq = 1'b1;
    @(negedge sys_clk);
    captureReq = 1'b0;
    // Far stage is wiped first while the near one still holds its digit
    for (int i = 0; i < 2000 && xferOut !== 2'b01; i++) @(negedge sys_clk);
    check(10'(xferOut), 10'h001, "far strobe not first");
    if (xferOut !== 2'b01) stop_test;
    check(farQ, 10'h3FF, "far stage not wiped");
    check(nearQ, farExp, "near stage lost digit");
    wait_idle;
    check(10'(pulses - p0), 10'h000, "reset during capture");
    check(digitOut, nearExp, "decoded digit");
    check(nearQ, nearExp, "near stage digit");
    check(farQ, farExp, "digit not shifted on");
  endtask
  task automatic t_preset(input logic h, input logic [6:0] c, input logic [9:0] n);
    stageIsHours = h;
    stageCount = c;
    p0 = pulses;
    request(1'b1, 1'b0);
    check(10'(pulses - p0), n, "preset pulse count");
  endtask
  initial begin
    t_powerup;
    t_capture(4'h7);
    t_capture(4'h0);
    t_preset(1'b1, 7'h17, 10'h001);
    t_preset(1'b1, 7'h16, 10'h000);
    t_preset(1'b0, 7'h3B, 10'h001);
    t_preset(1'b0, 7'h17, 10'h000);
    countBcd = 4'hC;
    repeat (3) @(negedge sys_clk);
    check(digitOut, 10'h3FF, "no digit above nine");
    check(nearQ, nearExp, "stored digit followed input");
    stop_test;
  end
endmodule // rpdl_host_bench
